// File: src/bfc_pkg.sv
// Package: register map, field positions, codes and reset values
package bfc_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_CONF = 4'h1;
	localparam logic [3:0] ADDR_MASK_LOW = 4'h2;
	localparam logic [3:0] ADDR_MASK_HIGH = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_SW_RESULT = 4'h5;
	localparam logic [3:0] ADDR_SENSE_RESULT = 4'h6;
	localparam logic [3:0] ADDR_BAL_RESULT = 4'h7;
	localparam logic [3:0] ADDR_DIAG_AUX = 4'h8;
	localparam logic [3:0] ADDR_AUX_RESULT = 4'h9;
	// Control register fields
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_GO_BIT = 3;
	localparam int CTRL_APPLY_BIT = 4;
	localparam int CTRL_SINK_LSB = 5;
	localparam int CTRL_PAUSE_BIT = 7;
	localparam int CTRL_THR_LSB = 8;
	// Configuration register fields
	localparam int CONF_AUX_SEL_LSB = 0;
	localparam int CONF_NUM_CELL_LSB = 8;
	// Status flag positions
	localparam int ST_SW_DONE = 0;
	localparam int ST_SENSE_DONE = 1;
	localparam int ST_BAL_DONE = 2;
	localparam int ST_AUX_READY = 3;
	localparam int ST_ABORT = 4;
	// Compare select codes
	localparam logic [2:0] SEL_SENSE_OPEN = 3'h2;
	localparam logic [2:0] SEL_BAL_OPEN = 3'h3;
	localparam logic [2:0] SEL_SWITCH = 3'h4;
	// Limits and reset values
	localparam logic [4:0] AUX_SEL_ALL = 5'h00;
	localparam logic [4:0] AUX_SEL_MAX = 5'h10;
	localparam logic [4:0] NUM_CELL_RESET = 5'h10;
	localparam logic [4:0] MAX_SWITCHES_ON = 5'h08;
	localparam logic [15:0] RESULT_ABORT = 16'hFFFF;
	localparam logic [15:0] AUX_DEFAULT = 16'h8000;
	localparam logic [10:0] THR_PAD = 11'h000;
	// Measurement carried from an ADC
	typedef struct packed {
		logic valid;
		logic [3:0] chan;
		logic [15:0] value;
	} bfc_meas_s;
	// Sequencer states
	typedef enum logic [0:0] {
		BFC_IDLE = 1'b0,
		BFC_RUN = 1'b1
	} bfc_state_e;
endpackage

// File: src/bfc_check.sv
// Module: balance switch and open wire comparison sequencer
`timescale 1ns/1ps
// What this block does
// - Flag switch when aux not below half cell
// - Check only switches enabled in test mask
// - Set switch check done when finished
// - Pause release drops test switches, resumes balancing
// - Abort sets flags, loads results with ones
// - Abort with locked aux restores default
// - Refuse bad aux channel or selection
// - Refuse when either ADC not continuous
// - Refuse switch check while balancing unpaused
// - Abort on too many switches or three adjacent switches
// - Locked aux value goes to diag aux during switch and balance open checks
// - Compare main or aux results to threshold
// - Set sense or balance open done flag
// - Never copy main value to diag main
module bfc_check import bfc_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Register port
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	// Measurement streams and ADC state
	input wire bfc_meas_s main_meas_in,
	input wire bfc_meas_s aux_meas_in,
	input wire logic main_on_in,
	input wire logic main_cont_in,
	input wire logic aux_on_in,
	input wire logic aux_cont_in,
	// Balancing
	input wire logic balance_active_in,
	input wire logic [15:0] balance_pattern_in,
	output logic [15:0] balance_switch_out,
	output logic [1:0] open_wire_sink_ctrl_out,
	output logic busy_out
);
	bfc_state_e state; // Sequencer state
	logic [2:0] sel; // Compare select field
	logic [3:0] open_wire_threshold; // Open wire threshold field
	logic [1:0] open_wire_sink_ctrl; // Sink and source control
	logic balance_pause; // Balancing paused
	logic [4:0] aux_sel; // Aux channel selection
	logic [4:0] num_cell; // Active cell count
	logic [15:0] test_mask; // Switch test mask
	logic [15:0] applied_mask; // Switches held on for the test
	logic [4:0] status; // Conversion status flags
	logic [15:0] switch_check_result; // Switch check fail bits
	logic [15:0] sense_open_result; // Sense pin fail bits
	logic [15:0] balance_open_result; // Balance pin fail bits
	logic [15:0] diag_aux_result; // Aux value used by the check
	logic [15:0] aux_channel_result; // Locked aux channel value
	logic [15:0] main_v [16]; // Latest main value per channel
	logic [2:0] run_sel; // Check being run
	logic [15:0] pending; // Channels still to compare
	logic [15:0] next_fail; // Fail bits built during a run
	logic go; // Start request
	logic [15:0] active_mask; // Channels below the cell count
	logic [15:0] sel_mask; // Channels the aux selection covers
	logic locked; // Aux locked on one channel
	logic [3:0] lock_ch; // Locked channel index
	logic sel_bad; // Selection gives no measurement
	logic adc_bad; // An ADC is off or single shot
	logic [4:0] on_count; // Switches enabled in the mask
	logic [15:0] adj3; // Three adjacent switches at a bit
	logic mask_bad; // Mask breaks the switch limits
	logic refuse; // Start refused
	logic [15:0] work_mask; // Channels a run compares
	logic [15:0] thr_full; // Threshold at measurement scale
	logic main_hit; // Main sample to compare now
	logic aux_hit; // Aux sample to compare now
	logic hit_fail; // Outcome of this comparison
	logic [3:0] hit_ch; // Channel being compared

	// Go is a write to control with the go bit while the sequencer is idle
	assign go = wr_in && addr_in == ADDR_CTRL && wdata_in[CTRL_GO_BIT]
		&& state == BFC_IDLE;

	// Decode the aux selection into channel masks
	always_comb begin
		locked = aux_sel != AUX_SEL_ALL && aux_sel <= AUX_SEL_MAX;
		lock_ch = 4'(aux_sel - 5'h01);
		active_mask = 16'((17'h00001 << num_cell) - 17'h00001);
		sel_mask = locked ? 16'(16'h0001 << lock_ch) : active_mask;
		sel_bad = aux_sel > AUX_SEL_MAX || num_cell == 5'h00
			|| (locked && aux_sel > num_cell);
		adc_bad = !main_on_in || !main_cont_in
			|| !aux_on_in || !aux_cont_in;
		thr_full = {1'b0, open_wire_threshold, THR_PAD};
	end

	// Adjacent triple detection, one term per starting switch
	genvar gi;
	generate
		for (gi = 0; gi < 14; gi++) begin : g_adj
			assign adj3[gi] = &test_mask[gi+2:gi];
		end
	endgenerate
	assign adj3[15:14] = 2'b00; // No triple can start at the top two

	// Count enabled switches and form the refusal
	always_comb begin
		on_count = 5'h00;
		for (int i = 0; i < 16; i++) begin
			on_count = on_count + 5'(test_mask[i]);
		end
		mask_bad = on_count > MAX_SWITCHES_ON || |adj3;
		refuse = sel_bad || adc_bad;
		if (wdata_in[2:0] == SEL_SWITCH) begin
			refuse = refuse || mask_bad
				|| (balance_active_in && !balance_pause);
		end
	end

	// Channel set for the run being started, from the written code
	always_comb begin
		case (wdata_in[2:0])
			SEL_SWITCH: work_mask = sel_mask & test_mask & active_mask;
			SEL_BAL_OPEN: work_mask = sel_mask & active_mask;
			default: work_mask = active_mask;
		endcase
	end

	// Per-sample comparison for the running check
	always_comb begin
		main_hit = state == BFC_RUN && run_sel == SEL_SENSE_OPEN
			&& main_meas_in.valid && pending[main_meas_in.chan];
		aux_hit = state == BFC_RUN && run_sel != SEL_SENSE_OPEN
			&& aux_meas_in.valid && pending[aux_meas_in.chan];
		hit_ch = main_hit ? main_meas_in.chan : aux_meas_in.chan;
		if (main_hit) begin
			hit_fail = main_meas_in.value < thr_full;
		end else if (run_sel == SEL_SWITCH) begin
			hit_fail = aux_meas_in.value
				>= {1'b0, main_v[aux_meas_in.chan][15:1]};
		end else begin
			hit_fail = aux_meas_in.value < thr_full;
		end
	end

	// Latest main value per channel
	generate
		for (gi = 0; gi < 16; gi++) begin : g_main
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					main_v[gi] <= 16'h0000;
				end else if (main_meas_in.valid
					&& main_meas_in.chan == 4'(gi)) begin
					main_v[gi] <= main_meas_in.value;
				end
			end
		end
	endgenerate

	// Control and configuration registers
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sel <= 3'h0;
			open_wire_sink_ctrl <= 2'h0;
			balance_pause <= 1'b0;
			open_wire_threshold <= 4'h0;
			aux_sel <= AUX_SEL_ALL;
			num_cell <= NUM_CELL_RESET;
			test_mask <= 16'h0000;
		end else if (wr_in) begin
			case (addr_in)
				ADDR_CTRL: begin
					sel <= wdata_in[CTRL_SEL_LSB+:3];
					open_wire_sink_ctrl <= wdata_in[CTRL_SINK_LSB+:2];
					balance_pause <= wdata_in[CTRL_PAUSE_BIT];
					open_wire_threshold <= wdata_in[CTRL_THR_LSB+:4];
				end
				ADDR_CONF: begin
					aux_sel <= wdata_in[CONF_AUX_SEL_LSB+:5];
					num_cell <= wdata_in[CONF_NUM_CELL_LSB+:5];
				end
				ADDR_MASK_LOW: test_mask[7:0] <= wdata_in[7:0];
				ADDR_MASK_HIGH: test_mask[15:8] <= wdata_in[7:0];
				default: ;
			endcase
		end
	end

	// Test switches: applied on request, dropped when pause ends
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			applied_mask <= 16'h0000;
		end else if (wr_in && addr_in == ADDR_CTRL) begin
			if (!wdata_in[CTRL_PAUSE_BIT] && balance_pause) begin
				applied_mask <= 16'h0000;
			end else if (wdata_in[CTRL_APPLY_BIT]) begin
				applied_mask <= test_mask;
			end
		end
	end

	// Paused balancing shows the test switches, else the pattern
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			balance_switch_out <= 16'h0000;
			open_wire_sink_ctrl_out <= 2'h0;
		end else begin
			balance_switch_out <= balance_pause ? applied_mask
				: balance_pattern_in;
			open_wire_sink_ctrl_out <= open_wire_sink_ctrl;
		end
	end

	// Sequencer: start, compare per channel, finish or abort
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= BFC_IDLE;
			run_sel <= 3'h0;
			pending <= 16'h0000;
			next_fail <= 16'h0000;
		end else begin
			case (state)
				BFC_IDLE: begin
					if (go && !refuse && (wdata_in[2:0] == SEL_SWITCH
						|| wdata_in[2:0] == SEL_SENSE_OPEN
						|| wdata_in[2:0] == SEL_BAL_OPEN)) begin
						run_sel <= wdata_in[2:0];
						state <= BFC_RUN;
						pending <= work_mask;
						next_fail <= 16'h0000;
					end
				end
				BFC_RUN: begin
					if (pending == 16'h0000) begin
						state <= BFC_IDLE;
					end else if (main_hit || aux_hit) begin
						pending[hit_ch] <= 1'b0;
						next_fail[hit_ch] <= hit_fail;
					end
				end
				default: state <= BFC_IDLE;
			endcase
		end
	end

	// Results, diagnostic aux copy and status flags
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			status <= 5'h00;
			switch_check_result <= 16'h0000;
			sense_open_result <= 16'h0000;
			balance_open_result <= 16'h0000;
			diag_aux_result <= AUX_DEFAULT;
			aux_channel_result <= AUX_DEFAULT;
		end else begin
			// Write one clears a flag; a set below wins
			if (wr_in && addr_in == ADDR_STATUS) begin
				status <= status & ~wdata_in[4:0];
			end
			if (aux_meas_in.valid && locked
				&& aux_meas_in.chan == lock_ch) begin
				aux_channel_result <= aux_meas_in.value;
				status[ST_AUX_READY] <= 1'b1;
			end
			if (aux_hit && locked && run_sel != SEL_SENSE_OPEN) begin
				diag_aux_result <= aux_meas_in.value;
			end
			if (go && refuse) begin
				status[ST_ABORT] <= 1'b1;
				status[ST_AUX_READY] <= 1'b1;
				if (locked) begin
					aux_channel_result <= AUX_DEFAULT;
				end
				case (wdata_in[2:0])
					SEL_SWITCH: begin
						status[ST_SW_DONE] <= 1'b1;
						switch_check_result <= RESULT_ABORT;
					end
					SEL_SENSE_OPEN: begin
						status[ST_SENSE_DONE] <= 1'b1;
						sense_open_result <= RESULT_ABORT;
					end
					SEL_BAL_OPEN: begin
						status[ST_BAL_DONE] <= 1'b1;
						balance_open_result <= RESULT_ABORT;
					end
					default: ;
				endcase
			end
			if (state == BFC_RUN && pending == 16'h0000) begin
				case (run_sel)
					SEL_SWITCH: begin
						status[ST_SW_DONE] <= 1'b1;
						switch_check_result <= next_fail;
					end
					SEL_SENSE_OPEN: begin
						status[ST_SENSE_DONE] <= 1'b1;
						sense_open_result <= next_fail;
					end
					default: begin
						status[ST_BAL_DONE] <= 1'b1;
						balance_open_result <= next_fail;
					end
				endcase
			end
		end
	end

	// Read data one cycle after the read strobe
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= 16'h0000;
		end else if (rd_in) begin
			case (addr_in)
				ADDR_CTRL: rdata_out <= {4'h0, open_wire_threshold,
					balance_pause, open_wire_sink_ctrl, 2'h0, sel};
				ADDR_CONF: rdata_out <= {3'h0, num_cell, 3'h0, aux_sel};
				ADDR_MASK_LOW: rdata_out <= {8'h00, test_mask[7:0]};
				ADDR_MASK_HIGH: rdata_out <= {8'h00, test_mask[15:8]};
				ADDR_STATUS: rdata_out <= {11'h000, status};
				ADDR_SW_RESULT: rdata_out <= switch_check_result;
				ADDR_SENSE_RESULT: rdata_out <= sense_open_result;
				ADDR_BAL_RESULT: rdata_out <= balance_open_result;
				ADDR_DIAG_AUX: rdata_out <= diag_aux_result;
				ADDR_AUX_RESULT: rdata_out <= aux_channel_result;
				default: rdata_out <= 16'h0000;
			endcase
		end else begin
			rdata_out <= 16'h0000;
		end
	end

	assign busy_out = state == BFC_RUN;
endmodule // bfc_check

// File: tb/bfc_check_asserts.sv
// Port assertions for the comparison sequencer
`timescale 1ns/1ps
module bfc_check_asserts import bfc_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Register writes and converter state
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic main_on_in,
	input wire logic aux_cont_in,
	input wire logic balance_active_in,
	input wire logic [15:0] balance_pattern_in,
	// Watched outputs
	input wire logic [15:0] balance_switch_out,
	input wire logic [1:0] open_wire_sink_ctrl_out,
	input wire logic busy_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	logic up; // Set one edge after reset
	logic pause; // Stored pause bit
	logic [15:0] mask; // Stored test mask
	// Mirror of pause bit and test mask
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			up <= 1'b0;
			pause <= 1'b0;
			mask <= 16'h0000;
		end else begin
			up <= 1'b1;
			if (wr_in && addr_in == ADDR_CTRL)
				pause <= wdata_in[CTRL_PAUSE_BIT];
			if (wr_in && addr_in == ADDR_MASK_LOW)
				mask[7:0] <= wdata_in[7:0];
			if (wr_in && addr_in == ADDR_MASK_HIGH)
				mask[15:8] <= wdata_in[7:0];
		end
	end
	// Go write taken while idle
	sequence go_s;
		wr_in && addr_in == ADDR_CTRL && wdata_in[CTRL_GO_BIT] && !busy_out;
	endsequence
	// Go write for the switch check
	sequence sw_go_s;
		go_s ##0 wdata_in[2:0] == SEL_SWITCH;
	endsequence
	main_off_a: assert property (go_s ##0 !main_on_in |=> !busy_out)
		else $error("run started with main off");
	aux_cont_a: assert property (go_s ##0 !aux_cont_in |=> !busy_out)
		else $error("run started with aux not continuous");
	pause_ref_a: assert property (sw_go_s ##0
		(balance_active_in && !pause) |=> !busy_out)
		else $error("switch check ran unpaused");
	mask_cnt_a: assert property (sw_go_s ##0
		($countones(mask) > 8) |=> !busy_out)
		else $error("switch check ran with too many");
	mask_adj_a: assert property (sw_go_s ##0
		(|(mask & (mask >> 1) & (mask >> 2))) |=> !busy_out)
		else $error("switch check ran with three adjacent");
	sw_out_a: assert property (up && !pause
		|=> balance_switch_out == $past(balance_pattern_in))
		else $error("pattern not driven");
	apply_a: assert property (wr_in && addr_in == ADDR_CTRL &&
		wdata_in[CTRL_APPLY_BIT] && wdata_in[CTRL_PAUSE_BIT]
		|=> ##1 balance_switch_out == $past(mask, 2))
		else $error("test mask not driven");
	sink_a: assert property (wr_in && addr_in == ADDR_CTRL |=> ##1
		(16'(open_wire_sink_ctrl_out) << 5)
		== ($past(wdata_in, 2) & 16'h0060))
		else $error("sink control wrong");
endmodule // bfc_check_asserts

// File: tb/bfc_cell_model.sv
// Cell stack model: round robin samples from both converters
`timescale 1ns/1ps
module bfc_cell_model import bfc_pkg::*; (
	// Clock
	input wire logic clk_in,
	// Converter running
	input wire logic main_run_in,
	input wire logic aux_run_in,
	// Settled levels per channel
	input wire logic [15:0] cell_v_in [16],
	input wire logic [15:0] fet_v_in [16],
	// Sample streams
	output bfc_meas_s main_meas_out = '0,
	output bfc_meas_s aux_meas_out = '0
);
	logic [3:0] ch = 4'h0; // Channel in turn
	logic [1:0] rnd = 2'h0; // Round count
	logic hold = 1'b0; // Idle cycle in slow rounds
	// Fast rounds send each cycle, slow rounds every other cycle
	always @(posedge clk_in) begin
		hold <= rnd[0] && !hold;
		main_meas_out.valid <= main_run_in && !hold;
		aux_meas_out.valid <= aux_run_in && !hold;
		main_meas_out.chan <= ch;
		aux_meas_out.chan <= ch;
		// Gaps carry a changing value, never the last one
		main_meas_out.value <= hold ? ~main_meas_out.value : cell_v_in[ch];
		aux_meas_out.value <= hold ? ~aux_meas_out.value : fet_v_in[ch];
		if (!hold) begin
			ch <= ch + 4'h1;
			if (ch == 4'hF)
				rnd <= rnd + 2'h1;
		end
	end
endmodule // bfc_cell_model

// File: tb/tb_top.sv
// Self-checking bench for the comparison sequencer
`timescale 1ns/1ps
module tb_top import bfc_pkg::*; ;
	logic clk_in = 1'b0, nrst_in = 1'b0; // Clock and reset
	logic [3:0] addr = 4'h0; // Register index
	logic [15:0] wdata = 16'h0000, pattern = 16'h0000; // Bus and pattern
	logic wr = 1'b0, rd = 1'b0, bal_act = 1'b0; // Strobes, balancing
	logic main_on = 1'b1, main_cont = 1'b1; // Main converter
	logic aux_on = 1'b1, aux_cont = 1'b1; // Aux converter
	logic [15:0] rdata, sw_out, m; // Outputs and test mask
	logic [1:0] sink; // Sink control
	logic busy; // Comparison running
	logic [3:0] th; // Threshold
	bfc_meas_s main_meas, aux_meas; // Sample streams
	logic [15:0] cell_v [16], fet_v [16]; // Channel levels
	int error_cnt = 0, checked = 0, seed = 96; // Counters and seed
	always #5 clk_in = ~clk_in;
	bfc_check u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.main_meas_in(main_meas), .aux_meas_in(aux_meas),
		.main_on_in(main_on), .main_cont_in(main_cont), .aux_on_in(aux_on),
		.aux_cont_in(aux_cont), .balance_active_in(bal_act),
		.balance_pattern_in(pattern), .balance_switch_out(sw_out),
		.open_wire_sink_ctrl_out(sink), .busy_out(busy));
	bfc_cell_model u_cells (.clk_in(clk_in),
		.main_run_in(main_on && main_cont), .aux_run_in(aux_on && aux_cont),
		.cell_v_in(cell_v), .fet_v_in(fet_v), .main_meas_out(main_meas),
		.aux_meas_out(aux_meas));
	// Compare and count
	task automatic chk(input logic [15:0] e, g, input string n);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	// One write cycle
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	// One read cycle, data checked in the following cycle
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e,
		input string n);
		@(posedge clk_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 chk(e, rdata, n);
	endtask
	// Control word from its fields
	function automatic logic [15:0] ctl(input logic [2:0] s,
		input logic go, ap, input logic [1:0] sk, input logic p,
		input logic [3:0] t);
		return {4'h0, t, p, sk, ap, go, s};
	endfunction
	// Start and wait for the run to end
	task automatic run(input logic [15:0] c);
		int n;
		wr_reg(ADDR_CTRL, c);
		for (n = 0; n < 300; n++) begin
			@(posedge clk_in);
			#1;
			if (busy === 1'b0)
				break;
		end
		if (n == 300)
			chk(16'h0000, 16'h0001, "busy timeout");
	endtask
	// Expected switch check result
	function automatic logic [15:0] exp_sw(input logic [15:0] mk);
		logic [15:0] r;
		for (int c = 0; c < 16; c++)
			r[c] = mk[c] && fet_v[c] >= (cell_v[c] >> 1);
		return r;
	endfunction
	// Expected open wire result
	function automatic logic [15:0] exp_ow(input logic mn, input logic [3:0] t);
		logic [15:0] r;
		for (int c = 0; c < 16; c++)
			r[c] = (mn ? cell_v[c] : fet_v[c]) < {1'b0, t, 11'h000};
		return r;
	endfunction
	// Refused start: env is balancing, main on, aux continuous
	task automatic abort(input logic [15:0] mk, cf, input logic [2:0] s,
		input logic [2:0] env, input logic [3:0] ra);
		wr_reg(ADDR_MASK_LOW, {8'h00, mk[7:0]});
		wr_reg(ADDR_MASK_HIGH, {8'h00, mk[15:8]});
		wr_reg(ADDR_CONF, cf);
		wr_reg(ADDR_CTRL, ctl(3'h0, 1'b0, 1'b0, 2'b00, !env[2], 4'h0));
		{bal_act, main_on, aux_cont} <= env;
		run(ctl(s, 1'b1, 1'b0, 2'b00, !env[2], 4'h0));
		rd_chk(ADDR_STATUS, 16'h0018 |
			(s == SEL_SWITCH ? 16'h0001 : s == SEL_SENSE_OPEN ?
			16'h0002 : 16'h0004), "abort flags");
		rd_chk(ra, RESULT_ABORT, "abort result");
		// Aux stopped, so no fresh sample overwrites the default
		if (cf[4:0] != 5'h00 && !env[0])
			rd_chk(ADDR_AUX_RESULT, AUX_DEFAULT, "aux default");
		{bal_act, main_on, aux_cont} <= 3'b011;
		wr_reg(ADDR_STATUS, 16'h001F);
	endtask
	// Verdict and end of run
	task automatic end_sim;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog
	initial begin
		#100000;
		error_cnt++;
		end_sim();
	end
	// Main sequence
	initial begin
		for (int c = 0; c < 16; c++) begin
			cell_v[c] = 16'($random(seed)) | 16'h0100;
			fet_v[c] = (cell_v[c] >> 1) - 16'h0002 + 16'($random(seed) & 3);
		end
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		pattern <= 16'($random(seed));
		rd_chk(ADDR_STATUS, 16'h0000, "status");
		rd_chk(ADDR_CONF, 16'h1000, "conf");
		rd_chk(ADDR_DIAG_AUX, AUX_DEFAULT, "diag aux");
		rd_chk(4'hA, 16'h0000, "unmapped");
		for (int r = 0; r < 4; r++) begin
			m = 16'($random(seed)) & (r[0] ? 16'hAAAA : 16'h5555);
			if (r == 0)
				m = 16'h5555;
			wr_reg(ADDR_MASK_LOW, {8'h00, m[7:0]});
			wr_reg(ADDR_MASK_HIGH, {8'h00, m[15:8]});
			wr_reg(ADDR_CTRL, ctl(3'h0, 1'b0, 1'b1, 2'b00, 1'b1, 4'h0));
			@(posedge clk_in);
			#1 chk(m, sw_out, "applied mask");
			run(ctl(SEL_SWITCH, 1'b1, 1'b0, 2'b00, 1'b1, 4'h0));
			rd_chk(ADDR_STATUS, 16'h0001, "switch done");
			rd_chk(ADDR_SW_RESULT, exp_sw(m), "switch result");
			wr_reg(ADDR_STATUS, 16'h001F);
		end
		wr_reg(ADDR_CTRL, 16'h0000);
		@(posedge clk_in);
		#1 chk(pattern, sw_out, "pattern");
		$display("test switch done");
		for (int k = 0; k < 2; k++) begin
			th = 4'($random(seed));
			wr_reg(ADDR_CTRL, ctl(3'h0, 1'b0, 1'b0, 2'b11, 1'b0, th));
			@(posedge clk_in);
			#1 chk(16'h0003, 16'(sink), "sink control");
			run(ctl(k ? SEL_BAL_OPEN : SEL_SENSE_OPEN, 1'b1, 1'b0, 2'b11,
				1'b0, th));
			rd_chk(ADDR_STATUS, k ? 16'h0004 : 16'h0002, "open done");
			rd_chk(k ? ADDR_BAL_RESULT : ADDR_SENSE_RESULT, exp_ow(k == 0, th),
				"open result");
			wr_reg(ADDR_CTRL, ctl(3'h0, 1'b0, 1'b0, 2'b00, 1'b0, th));
			wr_reg(ADDR_STATUS, 16'h001F);
		end
		$display("test open wire done");
		wr_reg(ADDR_CONF, 16'h1003);
		wr_reg(ADDR_MASK_LOW, 16'h0004);
		wr_reg(ADDR_MASK_HIGH, 16'h0000);
		wr_reg(ADDR_CTRL, ctl(3'h0, 1'b0, 1'b1, 2'b00, 1'b1, 4'h0));
		run(ctl(SEL_SWITCH, 1'b1, 1'b0, 2'b00, 1'b1, 4'h0));
		rd_chk(ADDR_DIAG_AUX, fet_v[2], "diag aux");
		rd_chk(ADDR_SW_RESULT, exp_sw(16'h0004), "locked");
		wr_reg(ADDR_STATUS, 16'h001F);
		abort(16'h0007, 16'h1003, SEL_SWITCH, 3'b011, ADDR_SW_RESULT);
		abort(16'h0000, 16'h1003, SEL_SWITCH, 3'b010, ADDR_SW_RESULT);
		abort(16'h1B6D, 16'h1000, SEL_SWITCH, 3'b011, ADDR_SW_RESULT);
		abort(16'h0000, 16'h1000, SEL_SENSE_OPEN, 3'b010,
			ADDR_SENSE_RESULT);
		abort(16'h0000, 16'h1000, SEL_BAL_OPEN, 3'b001, ADDR_BAL_RESULT);
		abort(16'h0000, 16'h1011, SEL_BAL_OPEN, 3'b011, ADDR_BAL_RESULT);
		abort(16'h0001, 16'h1000, SEL_SWITCH, 3'b111, ADDR_SW_RESULT);
		$display("test abort done");
		end_sim();
	end
endmodule // tb_top
bind bfc_check bfc_check_asserts u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
	.main_on_in(main_on_in), .aux_cont_in(aux_cont_in),
	.balance_active_in(balance_active_in),
	.balance_pattern_in(balance_pattern_in),
	.balance_switch_out(balance_switch_out),
	.open_wire_sink_ctrl_out(open_wire_sink_ctrl_out), .busy_out(busy_out));
